//--- design/irq_agg_defines.svh
`ifndef IRQ_AGG_DEFINES_SVH
`define IRQ_AGG_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SYS_CFG_ADDR       8'h00
`define MT_CTRL0_ADDR      8'h01
`define CSUM_ADDR          8'h02
`define PROT_SUM_ADDR      8'h03
`define IRQ_STATUS_ADDR    8'h04
`define IRQ_MASK_ADDR      8'h05
`define MODE_ADDR          8'h06
`define EVENT_ADDR         8'h07

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ZC_OE_BIT          1
`define DET_OE_BIT         2
`define KEY_LSB            0
`define KEY_MSB            8
`define KEY_BAK_LSB        16
`define KEY_BAK_MSB        24
`define PDN_OE_BIT         3
`define XTAL_OE_BIT        4
`define WDT_OE_BIT         5
`define REF_OE_BIT         6
`define DET_EN_BIT         12
`define DET_LEN_LSB        8
`define DET_LEN_MSB        11

// ----------------------------------------
// Event indices
// ----------------------------------------
`define EV_SELFCHK         0
`define EV_CSUM            1
`define EV_ZC              2
`define EV_DET             3
`define EV_PDN             4
`define EV_WDT             5
`define EV_XTAL            6
`define EV_REF             7

// ----------------------------------------
// Reset values, checksum target and detect mode code
// ----------------------------------------
`define SYS_CFG_RST        32'h0000_0000
`define MT_CTRL0_RST       32'h0000_0000
`define CSUM_RST           32'h0000_0000
`define ALL_ONES           32'hffff_ffff
`define MODE_DETECT        2'h1

`endif

//--- design/irq_agg_pkg.sv
`default_nettype none

package irq_agg_pkg;
   typedef struct packed {
      logic       zero_cross;
      logic       neg_polarity;
      logic       power_down;
      logic       wdt_overflow;
      logic       xtal_fail;
      logic       ref_damage;
      logic       cur_sample_valid;
      logic [23:0] cur_sample_abs;
   } event_in_type;

   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } reg_req_type;
endpackage

`default_nettype wire

//--- design/metering_interrupt_aggregator.sv
`timescale 1ns/10ps
`default_nettype none
`include "irq_agg_defines.svh"

module metering_interrupt_aggregator
   import irq_agg_pkg::*;
(
   // Clock and reset
   input  wire  logic        clock,
   input  wire  logic        nrst,
   // Register port
   input  wire  reg_req_type req,
   output var   logic [31:0] rdata,
   // Event sources (pins, synchronised here)
   input  wire  event_in_type events,
   input  wire  logic [23:0] det_threshold,
   // Host alert pin and interrupt
   output var   logic        alert,
   output var   logic        irq
);

   // ----------------------------------------
   // Assertion clocking
   // ----------------------------------------
   // Checks sleep through reset so the error flops can settle first
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Magnitude bits cross one by one; the source must hold them steady around each strobe
   event_in_type ev_s1_q;
   event_in_type ev_s2_q;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         ev_s1_q <= '0;
         ev_s2_q <= '0;
      end else begin
         ev_s1_q <= events;
         ev_s2_q <= ev_s1_q;
      end
   end

   // ----------------------------------------
   // Configuration registers
   // ----------------------------------------
   logic [31:0] sys_cfg_q;
   logic [31:0] mt_ctrl0_q;
   logic [31:0] csum_q;
   logic [31:0] prot_sum_q;
   logic [7:0]  mask_q;
   logic [1:0]  mode_q;

   function automatic logic is_wr(input reg_req_type r, input logic [7:0] a);
      return r.wr && (r.addr == a);
   endfunction

   always_ff @(posedge clock) begin
      if (!nrst) begin
         sys_cfg_q  <= `SYS_CFG_RST;
         mt_ctrl0_q <= `MT_CTRL0_RST;
         csum_q     <= `CSUM_RST;
         prot_sum_q <= '0;
         mask_q     <= 8'hff;
         mode_q     <= 2'h0;
      end else begin
         if (is_wr(req, `SYS_CFG_ADDR)) begin
            sys_cfg_q <= req.wdata;
         end
         if (is_wr(req, `MT_CTRL0_ADDR)) begin
            mt_ctrl0_q <= req.wdata;
         end
         if (is_wr(req, `CSUM_ADDR)) begin
            csum_q <= req.wdata;
         end
         if (is_wr(req, `PROT_SUM_ADDR)) begin
            prot_sum_q <= req.wdata;
         end
         if (is_wr(req, `IRQ_MASK_ADDR)) begin
            mask_q <= req.wdata[7:0];
         end
         if (is_wr(req, `MODE_ADDR)) begin
            mode_q <= req.wdata[1:0];
         end
      end
   end

   // ----------------------------------------
   // Configuration checks
   // ----------------------------------------
   logic selfchk_err_q;
   logic csum_err_q;
   logic [31:0] cfg_total;

   always_comb begin
      cfg_total = prot_sum_q + csum_q;
   end

   // Both checks run every cycle, regardless of mode
   always_ff @(posedge clock) begin
      if (!nrst) begin
         selfchk_err_q <= 1'b0;
         csum_err_q    <= 1'b0;
      end else begin
         selfchk_err_q <= (sys_cfg_q[`KEY_BAK_MSB:`KEY_BAK_LSB] != ~sys_cfg_q[`KEY_MSB:`KEY_LSB]);
         csum_err_q    <= (cfg_total != `ALL_ONES);
      end
   end

   selfchk_cmp_a: assert property ((sys_cfg_q[24:16] == ~sys_cfg_q[8:0]) |=> !selfchk_err_q)
      else $error("matching backup flagged as error");
   csum_cmp_a: assert property ((cfg_total == `ALL_ONES) |=> !csum_err_q)
      else $error("balanced checksum flagged as error");

   // ----------------------------------------
   // Current detection window
   // ----------------------------------------
   logic [3:0] det_run_q;
   logic       det_active_q;
   logic [3:0] det_len;

   always_comb begin
      det_len = mt_ctrl0_q[`DET_LEN_MSB:`DET_LEN_LSB];
   end

   // Run counter saturates so a long burst cannot wrap back below the window
   // consecutive sample count
   always_ff @(posedge clock) begin
      if (!nrst) begin
         det_run_q    <= 4'h0;
         det_active_q <= 1'b0;
      end else if (!mt_ctrl0_q[`DET_EN_BIT]) begin
         det_run_q    <= 4'h0;
         det_active_q <= 1'b0;
      end else if (ev_s2_q.cur_sample_valid) begin
         if (ev_s2_q.cur_sample_abs > det_threshold) begin
            if (det_run_q != 4'hf) begin
               det_run_q <= det_run_q + 4'h1;
            end
            if ((det_run_q + 4'h1) >= det_len) begin
               det_active_q <= 1'b1;
            end
         end else begin
            det_run_q    <= 4'h0;
            det_active_q <= 1'b0;
         end
      end
   end

   det_off_a: assert property (!mt_ctrl0_q[`DET_EN_BIT] |=> !det_active_q)
      else $error("detection active while disabled");
   det_drop_a: assert property ((ev_s2_q.cur_sample_valid && !(ev_s2_q.cur_sample_abs > det_threshold))
      |=> !det_active_q)
      else $error("detection held past a quiet sample");

   // ----------------------------------------
   // Event flags and status
   // ----------------------------------------
   logic [7:0] active;
   logic [7:0] status_q;
   logic       zc_prev_q;
   logic       zc_edge;

   always_comb begin
      zc_edge = ev_s2_q.neg_polarity ^ zc_prev_q;
      active                = 8'h00;
      active[`EV_SELFCHK]   = selfchk_err_q;
      active[`EV_CSUM]      = csum_err_q;
      active[`EV_ZC]        = zc_edge;
      active[`EV_DET]       = det_active_q;
      active[`EV_PDN]       = ev_s2_q.power_down;
      active[`EV_WDT]       = ev_s2_q.wdt_overflow;
      active[`EV_XTAL]      = ev_s2_q.xtal_fail;
      active[`EV_REF]       = ev_s2_q.ref_damage;
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         zc_prev_q <= 1'b0;
      end else begin
         zc_prev_q <= ev_s2_q.neg_polarity;
      end
   end

   // Events merge after the clear so a same-cycle event is never lost
   // sticky flags, set beats clear
   always_ff @(posedge clock) begin
      if (!nrst) begin
         status_q <= 8'h00;
      end else if (is_wr(req, `IRQ_STATUS_ADDR)) begin
         status_q <= (status_q & ~req.wdata[7:0]) | active;
      end else begin
         status_q <= status_q | active;
      end
   end

   flag_sticky_a: assert property ((status_q[`EV_PDN] && !is_wr(req, `IRQ_STATUS_ADDR)) |=> status_q[`EV_PDN])
      else $error("flag lost without clear");
   flag_set_a: assert property (ev_s2_q.wdt_overflow |=> status_q[`EV_WDT])
      else $error("watchdog flag not set");
   selfchk_flag_a: assert property (selfchk_err_q |=> status_q[`EV_SELFCHK])
      else $error("self-check flag not set");
   csum_flag_a: assert property (csum_err_q |=> status_q[`EV_CSUM])
      else $error("checksum flag not set");
   zc_flag_a: assert property (zc_edge |=> status_q[`EV_ZC])
      else $error("zero-crossing flag not set");
   det_flag_a: assert property (det_active_q |=> status_q[`EV_DET])
      else $error("detection flag not set");
   flag_clear_a: assert property ((is_wr(req, `IRQ_STATUS_ADDR) && req.wdata[`EV_PDN] && !active[`EV_PDN])
      |=> !status_q[`EV_PDN])
      else $error("power-down flag not cleared");
   mode_flag_a: assert property (((mode_q == `MODE_DETECT) && det_active_q) |=> status_q[`EV_DET])
      else $error("detect mode stopped the flags");

   // ----------------------------------------
   // Alert pin combination
   // ----------------------------------------
   logic alert_d;
   logic det_unmasked;

   always_comb begin
      det_unmasked = (mode_q == `MODE_DETECT);
      alert_d = 1'b0;
      alert_d = alert_d | selfchk_err_q;
      alert_d = alert_d | csum_err_q;
      alert_d = alert_d | (sys_cfg_q[`ZC_OE_BIT] & ev_s2_q.neg_polarity);
      alert_d = alert_d | (det_active_q & (det_unmasked | sys_cfg_q[`DET_OE_BIT]));
      alert_d = alert_d | (ev_s2_q.power_down & mt_ctrl0_q[`PDN_OE_BIT]);
      alert_d = alert_d | (ev_s2_q.wdt_overflow & mt_ctrl0_q[`WDT_OE_BIT]);
      alert_d = alert_d | (ev_s2_q.xtal_fail & mt_ctrl0_q[`XTAL_OE_BIT]);
      alert_d = alert_d | (ev_s2_q.ref_damage & mt_ctrl0_q[`REF_OE_BIT]);
   end

   // One flop on the pin trades a cycle of delay for a glitch-free alert
   // registered pin drive
   always_ff @(posedge clock) begin
      if (!nrst) begin
         alert <= 1'b0;
         irq   <= 1'b0;
      end else begin
         alert <= alert_d;
         irq   <= |(status_q & ~mask_q);
      end
   end

   selfchk_pin_a: assert property (selfchk_err_q |=> alert)
      else $error("self-check error did not raise alert");
   csum_pin_a: assert property (csum_err_q |=> alert)
      else $error("checksum error did not raise alert");
   zc_pin_a: assert property ((sys_cfg_q[`ZC_OE_BIT] && ev_s2_q.neg_polarity) |=> alert)
      else $error("negative polarity not shown");
   det_mode_a: assert property ((det_active_q && det_unmasked) |=> alert)
      else $error("detection in detect mode not shown");
   det_oe_a: assert property ((det_active_q && sys_cfg_q[`DET_OE_BIT]) |=> alert)
      else $error("enabled detection not shown");
   pdn_gate_a: assert property ((ev_s2_q.power_down && mt_ctrl0_q[`PDN_OE_BIT]) |=> alert)
      else $error("enabled power-down not shown");
   wdt_gate_a: assert property ((ev_s2_q.wdt_overflow && mt_ctrl0_q[`WDT_OE_BIT]) |=> alert)
      else $error("enabled watchdog overflow not shown");
   xtal_gate_a: assert property ((ev_s2_q.xtal_fail && mt_ctrl0_q[`XTAL_OE_BIT]) |=> alert)
      else $error("enabled oscillator failure not shown");
   ref_gate_a: assert property ((ev_s2_q.ref_damage && mt_ctrl0_q[`REF_OE_BIT]) |=> alert)
      else $error("enabled reference damage not shown");
   alert_quiet_a: assert property (!alert_d |=> !alert)
      else $error("alert high with no source");
   irq_level_a: assert property ((|(status_q & ~mask_q)) |=> irq)
      else $error("unmasked flag did not raise irq");
   irq_quiet_a: assert property (!(|(status_q & ~mask_q)) |=> !irq)
      else $error("irq high with every flag masked or clear");

   // ----------------------------------------
   // Read port
   // ----------------------------------------
   // Idle cycles return zero so stale data never lingers on the bus
   always_ff @(posedge clock) begin
      if (!nrst) begin
         rdata <= 32'h0000_0000;
      end else if (req.rd) begin
         if (req.addr == `SYS_CFG_ADDR) begin
            rdata <= sys_cfg_q;
         end else if (req.addr == `MT_CTRL0_ADDR) begin
            rdata <= mt_ctrl0_q;
         end else if (req.addr == `CSUM_ADDR) begin
            rdata <= csum_q;
         end else if (req.addr == `PROT_SUM_ADDR) begin
            rdata <= prot_sum_q;
         end else if (req.addr == `IRQ_STATUS_ADDR) begin
            rdata <= {24'h000000, status_q};
         end else if (req.addr == `IRQ_MASK_ADDR) begin
            rdata <= {24'h000000, mask_q};
         end else if (req.addr == `MODE_ADDR) begin
            rdata <= {30'h00000000, mode_q};
         end else if (req.addr == `EVENT_ADDR) begin
            rdata <= {24'h000000, active};
         end else begin
            rdata <= 32'h0000_0000;
         end
      end else begin
         rdata <= 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Cover points
   // ----------------------------------------
   zc_cov_c: cover property (zc_edge ##1 alert);
   det_cov_c: cover property (det_active_q ##1 alert);
   clear_cov_c: cover property (is_wr(req, `IRQ_STATUS_ADDR) && |status_q);
   pdn_cov_c: cover property ((ev_s2_q.power_down && mt_ctrl0_q[`PDN_OE_BIT]) ##1 alert);
   mode_cov_c: cover property (det_active_q && det_unmasked && !sys_cfg_q[`DET_OE_BIT]);

endmodule
`default_nettype wire

//--- tb/host_alert_model.sv
`timescale 1ns/10ps
`default_nettype none

module host_alert_model (
   // Clock and reset
   input  wire logic       clock,
   input  wire logic       nrst,
   // Alert pin from the device
   input  wire logic       alert,
   output var  logic [7:0] rise_count
);
   // ----------------------------------------
   // Host side edge counter
   // ----------------------------------------
   logic alert_q;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         alert_q    <= 1'b0;
         rise_count <= 8'h00;
      end else begin
         alert_q <= alert;
         if (alert && !alert_q) begin
            rise_count <= rise_count + 8'h01;
         end
      end
   end
endmodule

`default_nettype wire

//--- tb/metering_interrupt_aggregator_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "irq_agg_defines.svh"

module metering_interrupt_aggregator_tb
   import irq_agg_pkg::*;
;
   logic         clock     = 1'b0;
   logic         nrst      = 1'b0;
   reg_req_type  req       = '0;
   event_in_type ev        = '0;
   logic [23:0]  thr       = 24'h000100;
   logic [31:0]  rdata;
   logic         alert;
   logic         irq;
   logic [7:0]   rises;
   logic [31:0]  d;
   int           err_count = 0;
   int           checked   = 0;

   always #2.5 clock = ~clock;

   metering_interrupt_aggregator dut (.clock(clock), .nrst(nrst), .req(req), .rdata(rdata),
      .events(ev), .det_threshold(thr), .alert(alert), .irq(irq));
   host_alert_model host (.clock(clock), .nrst(nrst), .alert(alert), .rise_count(rises));

   // ----------------------------------------
   // Bus and compare helpers
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // One idle cycle after each strobe keeps a driver from assigning req twice at one edge
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clock);
      req <= '0;
      #1;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clock);
      req <= '0;
      #1 d = rdata;
   endtask

   task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic chk_bit(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask

   function automatic logic [31:0] cfg(input logic [8:0] k);
      return {7'h00, ~k, 7'h00, k};
   endfunction

   task automatic set_pin(input int i, input logic v);
      @(posedge clock);
      case (i)
         0: ev.power_down <= v;
         1: ev.wdt_overflow <= v;
         2: ev.xtal_fail <= v;
         default: ev.ref_damage <= v;
      endcase
   endtask

   task automatic sample(input logic [23:0] m);
      @(posedge clock);
      ev.cur_sample_valid <= 1'b1;
      ev.cur_sample_abs   <= m;
      @(posedge clock);
      ev.cur_sample_valid <= 1'b0;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset();
      tick(3);
      chk_bit("alert", 1'b1, alert);
      chk_bit("irq", 1'b0, irq);
      rd(`IRQ_STATUS_ADDR);
      chk_word("status", 32'h0000_0003, d);
      rd(`IRQ_MASK_ADDR);
      chk_word("mask", 32'h0000_00ff, d);
      $display("test reset done");
   endtask

   task automatic t_config();
      wr(`SYS_CFG_ADDR, cfg(9'h000));
      tick(5);
      chk_bit("alert", 1'b1, alert);
      wr(`CSUM_ADDR, 32'hffff_fff0);
      wr(`PROT_SUM_ADDR, 32'h0000_000f);
      wr(`IRQ_STATUS_ADDR, 32'h0000_00ff);
      tick(5);
      chk_bit("alert", 1'b0, alert);
      rd(`IRQ_STATUS_ADDR);
      chk_word("status", 32'h0000_0000, d);
      // Backup off by one bit only, under full mask
      wr(`SYS_CFG_ADDR, 32'h01fe_0000);
      tick(5);
      chk_bit("alert", 1'b1, alert);
      rd(`IRQ_STATUS_ADDR);
      chk_word("status", 32'h0000_0001, d);
      chk_bit("irq", 1'b0, irq);
      rd(`SYS_CFG_ADDR);
      chk_word("sys cfg", 32'h01fe_0000, d);
      wr(`SYS_CFG_ADDR, cfg(9'h000));
      wr(`IRQ_STATUS_ADDR, 32'h0000_00ff);
      tick(5);
      chk_bit("alert", 1'b0, alert);
      $display("test config done");
   endtask

   task automatic t_pins();
      int en_bit [4] = '{3, 5, 4, 6};
      for (int i = 0; i < 4; i++) begin
         for (int e = 0; e < 2; e++) begin
            wr(`MT_CTRL0_ADDR, 32'(e) << en_bit[i]);
            wr(`IRQ_MASK_ADDR, ~(32'h0000_0010 << i));
            set_pin(i, 1'b1);
            tick(5);
            chk_bit("alert", e[0], alert);
            chk_bit("irq", 1'b1, irq);
            rd(`IRQ_STATUS_ADDR);
            chk_word("status", 32'h0000_0010 << i, d);
            rd(`EVENT_ADDR);
            chk_word("events", 32'h0000_0010 << i, d);
            set_pin(i, 1'b0);
            tick(5);
            wr(`IRQ_STATUS_ADDR, 32'h0000_00ff);
         end
      end
      $display("test pins done");
   endtask

   task automatic t_zc();
      logic [7:0] r0;
      wr(`SYS_CFG_ADDR, cfg(9'h002));
      r0 = rises;
      for (int k = 0; k < 4; k++) begin
         @(posedge clock);
         ev.neg_polarity <= ~ev.neg_polarity;
         tick(5);
         chk_bit("alert", ev.neg_polarity, alert);
      end
      chk_word("rises", {24'h0, r0 + 8'h02}, {24'h0, rises});
      rd(`IRQ_STATUS_ADDR);
      chk_word("status", 32'h0000_0004, d);
      wr(`SYS_CFG_ADDR, cfg(9'h000));
      @(posedge clock);
      ev.neg_polarity <= 1'b1;
      tick(5);
      chk_bit("alert", 1'b0, alert);
      @(posedge clock);
      ev.neg_polarity <= 1'b0;
      tick(5);
      wr(`IRQ_STATUS_ADDR, 32'h0000_00ff);
      $display("test zero cross done");
   endtask

   task automatic t_det();
      wr(`MT_CTRL0_ADDR, 32'h0000_1400);
      repeat (3) sample(24'h000200);
      sample(24'h000010);
      tick(5);
      rd(`IRQ_STATUS_ADDR);
      chk_word("status", 32'h0000_0000, d);
      repeat (4) sample(24'h000200);
      tick(5);
      rd(`IRQ_STATUS_ADDR);
      chk_word("status", 32'h0000_0008, d);
      chk_bit("alert", 1'b0, alert);
      wr(`MODE_ADDR, 32'h0000_0001);
      tick(5);
      chk_bit("alert", 1'b1, alert);
      wr(`MODE_ADDR, 32'h0000_0000);
      wr(`SYS_CFG_ADDR, cfg(9'h004));
      tick(5);
      chk_bit("alert", 1'b1, alert);
      sample(24'h000010);
      tick(5);
      chk_bit("alert", 1'b0, alert);
      wr(`SYS_CFG_ADDR, cfg(9'h000));
      $display("test detection done");
   endtask

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial begin
      repeat (4) @(posedge clock);
      nrst <= 1'b1;
      t_reset();
      t_config();
      t_pins();
      t_zc();
      t_det();
      end_of_test();
   end

   // Whole run is a few hundred cycles; this cuts off a hang
   initial begin
      #100000;
      err_count++;
      end_of_test();
   end
endmodule

`default_nettype wire
